// ---- hw/dpau_unit.sv ----
// Summary of operation
// - op 35: quotient to A+1, A kept
// - op 35 uses upper half, no remainder
// - op 36: pair divided, quotient A, remainder A+1
// - op 36 dividend shifted right one bit
// - op 72: j is a minor opcode
// - j 4: add halves in place
// - j 5: subtract halves in place
// - j 6: add thirds in place
// - j 7: subtract thirds in place
// - halves signed at 35, 17, isolated
// - thirds signed at 35, 23, 11, isolated
// - partitioned ops never set carry, overflow
// - partitioned ops take 4.0 or 8.0 us
// - logical ops bitwise, no carries
// - logical A+1 from 33 goes 34
// - divisor not above upper half: overflow, interrupt
// - remainder takes the dividend sign
`timescale 1ns/1ps
module dpau_unit (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire logic               start_i,
    input  wire dpau_pkg::dpau_req_t req_i,
    output logic                    ready_o,
    output logic                    accept_o,
    output logic                    busy_o,
    output logic                    done_o,
    output dpau_pkg::dpau_wr_t      wr_a_o,
    output dpau_pkg::dpau_wr_t      wr_a1_o,
    output logic                    overflow_o,
    output logic                    error_irq_o
);
    import dpau_pkg::*;

    dpau_state_t               state_r;    // sequencing state
    logic [CNT_W-1:0]          cnt_r;      // cycles left before completion
    dpau_req_t                 req_r;      // captured request, for checks
    dpau_wr_t                  res_a_r;    // pending write to A
    dpau_wr_t                  res_a1_r;   // pending write to A+1
    logic                      res_ovf_r;  // pending divide overflow
    logic                      known;      // opcode/minor code served here
    logic                      is_div;     // either divide
    logic [CNT_W-1:0]          cyc_sel;    // total cycles of this op
    logic [ADDR_W-1:0]         addr_a;     // film address of A
    logic [ADDR_W-1:0]         addr_a1;    // film address of A+1
    logic [WORD_W-1:0]         part_res;   // partitioned result
    logic [WORD_W-1:0]         u_neg;      // complement of U, for subtract
    logic                      sd;         // dividend sign
    logic                      su;         // divisor sign
    logic [WORD_W-1:0]         amag;       // dividend upper magnitude
    logic [WORD_W-1:0]         a1mag;      // dividend lower magnitude
    logic [WORD_W-1:0]         umag;       // divisor magnitude
    logic [2*WORD_W-1:0]       dvd;        // shifted dividend magnitude
    logic [2*WORD_W-1:0]       dvs;        // divisor, zero guarded
    logic [2*WORD_W-1:0]       quo72;      // raw quotient
    logic [2*WORD_W-1:0]       rem72;      // raw remainder
    logic [WORD_W-1:0]         q_sgn;      // signed quotient
    logic [WORD_W-1:0]         r_sgn;      // signed remainder
    logic                      div_ovf;    // overflow condition
    dpau_wr_t                  nxt_a;      // computed write to A
    dpau_wr_t                  nxt_a1;     // computed write to A+1

    // requests are taken only while idle and only for ops served here
    assign ready_o  = (state_r == ST_IDLE);
    assign accept_o = start_i && ready_o && known;
    assign busy_o   = (state_r == ST_RUN);

    // decode and register addressing
    always_comb begin
        is_div = (req_i.opcode == OP_DIV_SINGLE) || (req_i.opcode == OP_DIV_FRAC);
        known  = is_div || (req_i.opcode == OP_LOG_OR) || (req_i.opcode == OP_LOG_XOR)
                 || (req_i.opcode == OP_LOG_AND)
                 || ((req_i.opcode == OP_PART) && (req_i.j >= J_ADD_HALF)
                     && (req_i.j <= J_SUB_THIRD));
        addr_a = A_BASE_ADDR + ADDR_W'(req_i.a_sel);
        // no wrap: A15 plus one is the unassigned word above the bank
        addr_a1 = addr_a + 7'h01;
        // divide and partitioned/logical timing per bank case
        if (is_div) begin
            cyc_sel = req_i.same_bank ? CYC_DIV_SAME : CYC_DIV_ALT;
        end else begin
            cyc_sel = req_i.same_bank ? CYC_PART_SAME : CYC_PART_ALT;
        end
    end

    // partitioned add/subtract, every field its own ones'-complement sum
    always_comb begin
        u_neg = ~req_i.u_val;
        case (req_i.j)
            J_ADD_HALF: begin
                part_res = {oc_add18(req_i.a_val[35:18], req_i.u_val[35:18]),
                            oc_add18(req_i.a_val[17:0], req_i.u_val[17:0])};
            end
            J_SUB_HALF: begin
                part_res = {oc_add18(req_i.a_val[35:18], u_neg[35:18]),
                            oc_add18(req_i.a_val[17:0], u_neg[17:0])};
            end
            J_ADD_THIRD: begin
                part_res = {oc_add12(req_i.a_val[35:24], req_i.u_val[35:24]),
                            oc_add12(req_i.a_val[23:12], req_i.u_val[23:12]),
                            oc_add12(req_i.a_val[11:0], req_i.u_val[11:0])};
            end
            J_SUB_THIRD: begin
                part_res = {oc_add12(req_i.a_val[35:24], u_neg[35:24]),
                            oc_add12(req_i.a_val[23:12], u_neg[23:12]),
                            oc_add12(req_i.a_val[11:0], u_neg[11:0])};
            end
            default: begin
                part_res = req_i.a_val;
            end
        endcase
    end

    // sign-magnitude divide on ones'-complement operands
    always_comb begin
        sd    = req_i.a_val[WORD_W-1];
        su    = req_i.u_val[WORD_W-1];
        amag  = sd ? ~req_i.a_val : req_i.a_val;
        a1mag = sd ? ~req_i.a1_val : req_i.a1_val;
        umag  = su ? ~req_i.u_val : req_i.u_val;
        // single divide takes only the upper half as dividend
        if (req_i.opcode == OP_DIV_SINGLE) begin
            dvd = {amag, {WORD_W{1'b0}}} >> 1;
        end else begin
            dvd = {amag, a1mag} >> 1;
        end
        div_ovf = (umag <= amag);
        // zero divisor is already overflow; guard keeps the divider defined
        dvs   = div_ovf ? 72'h1 : {{WORD_W{1'b0}}, umag};
        quo72 = dvd / dvs;
        rem72 = dvd % dvs;
        // nothing is delivered on overflow, so the data lines stay quiet too
        q_sgn = div_ovf ? '0 : ((sd ^ su) ? ~quo72[WORD_W-1:0] : quo72[WORD_W-1:0]);
        r_sgn = div_ovf ? '0 : (sd ? ~rem72[WORD_W-1:0] : rem72[WORD_W-1:0]);
    end

    // routing of results to the two write ports
    always_comb begin
        nxt_a  = '0;
        nxt_a1 = '0;
        case (req_i.opcode)
            OP_DIV_SINGLE: begin
                // quotient only; the source register is left alone
                nxt_a1 = '{en: !div_ovf, addr: addr_a1, data: q_sgn};
            end
            OP_DIV_FRAC: begin
                nxt_a  = '{en: !div_ovf, addr: addr_a, data: q_sgn};
                nxt_a1 = '{en: !div_ovf, addr: addr_a1, data: r_sgn};
            end
            OP_PART: begin
                nxt_a = '{en: 1'b1, addr: addr_a, data: part_res};
            end
            OP_LOG_OR: begin
                nxt_a1 = '{en: 1'b1, addr: addr_a1, data: req_i.a_val | req_i.u_val};
            end
            OP_LOG_XOR: begin
                nxt_a1 = '{en: 1'b1, addr: addr_a1, data: req_i.a_val ^ req_i.u_val};
            end
            OP_LOG_AND: begin
                nxt_a1 = '{en: 1'b1, addr: addr_a1, data: req_i.a_val & req_i.u_val};
            end
            default: begin
                nxt_a  = '0;
                nxt_a1 = '0;
            end
        endcase
    end

    // sequencer: counts the documented execution time
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (accept_o) begin
                        state_r <= ST_RUN;
                        cnt_r   <= cyc_sel - 10'h002;
                    end
                end
                ST_RUN: begin
                    if (cnt_r == '0) begin
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 10'h001;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // results computed at accept, held until the time is up
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            req_r     <= '0;
            res_a_r   <= '0;
            res_a1_r  <= '0;
            res_ovf_r <= 1'b0;
        end else if (accept_o) begin
            req_r     <= req_i;
            res_a_r   <= nxt_a;
            res_a1_r  <= nxt_a1;
            // only divides can flag overflow
            res_ovf_r <= is_div && div_ovf;
        end
    end

    // completion outputs, one-cycle pulses except the overflow level
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            done_o      <= 1'b0;
            wr_a_o      <= '0;
            wr_a1_o     <= '0;
            error_irq_o <= 1'b0;
        end else begin
            done_o      <= busy_o && (cnt_r == '0);
            wr_a_o      <= (busy_o && (cnt_r == '0)) ? res_a_r : '0;
            wr_a1_o     <= (busy_o && (cnt_r == '0)) ? res_a1_r : '0;
            error_irq_o <= busy_o && (cnt_r == '0) && res_ovf_r;
        end
    end

    // overflow level follows the latest completed op
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            overflow_o <= 1'b0;
        end else if (busy_o && (cnt_r == '0)) begin
            overflow_o <= res_ovf_r;
        end
    end

    // checks
    chk_part_alt_time: assert property (@(posedge clk_i) disable iff (reset_i)
        accept_o && (req_i.opcode == OP_PART) && !req_i.same_bank |-> ##80 done_o)
        else $error("partitioned op not done after 80 cycles");
    chk_part_same_time: assert property (@(posedge clk_i) disable iff (reset_i)
        accept_o && (req_i.opcode == OP_PART) && req_i.same_bank
        |-> ##1 !done_o [*8] ##152 done_o)
        else $error("partitioned op not done after 160 cycles");
    chk_part_no_flag: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o && (req_r.opcode == OP_PART) |-> !overflow_o && !error_irq_o && !wr_a1_o.en)
        else $error("partitioned op raised a flag");
    chk_half_isolate: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o && (req_r.opcode == OP_PART) && (req_r.j == J_ADD_HALF)
        |-> wr_a_o.data[17:0] == oc_add18(req_r.a_val[17:0], req_r.u_val[17:0]))
        else $error("lower half sum wrong");
    chk_third_sub: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o && (req_r.opcode == OP_PART) && (req_r.j == J_SUB_THIRD)
        |-> wr_a_o.data[23:12] == oc_add12(req_r.a_val[23:12], ~req_r.u_val[23:12]))
        else $error("middle third difference wrong");
    chk_single_target: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o && (req_r.opcode == OP_DIV_SINGLE)
        |-> !wr_a_o.en && (wr_a1_o.addr == A_BASE_ADDR + ADDR_W'(req_r.a_sel) + 7'h01))
        else $error("single divide wrote the wrong register");
    chk_div_overflow: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o && overflow_o |-> error_irq_o && !wr_a_o.en && !wr_a1_o.en)
        else $error("divide overflow without interrupt");
    chk_rem_sign: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_a1_o.en && (req_r.opcode == OP_DIV_FRAC)
        |-> wr_a1_o.data[WORD_W-1] == req_r.a_val[WORD_W-1])
        else $error("remainder sign differs from dividend");
    chk_logic_addr: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_a1_o.en && (req_r.opcode == OP_LOG_XOR) && (req_r.a_sel == 4'hF)
        |-> (wr_a1_o.addr == 7'h1C) && (wr_a1_o.data == (req_r.a_val ^ req_r.u_val)))
        else $error("logical result misplaced");
    chk_done_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o |=> !done_o && (ready_o || $past(accept_o)))
        else $error("done longer than one cycle");
    // a refused code never starts, and nothing is taken while running
    chk_minor_refuse: assert property (@(posedge clk_i) disable iff (reset_i)
        (req_i.opcode == OP_PART) && ((req_i.j < J_ADD_HALF) || (req_i.j > J_SUB_THIRD))
        |-> !accept_o)
        else $error("partitioned op with bad minor code taken");
    chk_busy_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        busy_o |-> !accept_o && !ready_o)
        else $error("request taken while running");
    chk_half_sub_upper: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o && (req_r.opcode == OP_PART) && (req_r.j == J_SUB_HALF)
        |-> wr_a_o.data[35:18] == oc_add18(req_r.a_val[35:18], ~req_r.u_val[35:18]))
        else $error("upper half difference wrong");
    chk_third_add_upper: assert property (@(posedge clk_i) disable iff (reset_i)
        done_o && (req_r.opcode == OP_PART) && (req_r.j == J_ADD_THIRD)
        |-> wr_a_o.data[35:24] == oc_add12(req_r.a_val[35:24], req_r.u_val[35:24]))
        else $error("upper third sum wrong");
    chk_frac_quot_addr: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_a_o.en && (req_r.opcode == OP_DIV_FRAC)
        |-> wr_a1_o.en && (wr_a_o.addr == A_BASE_ADDR + ADDR_W'(req_r.a_sel)))
        else $error("fractional quotient misplaced");
    chk_logic_or_bits: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_a1_o.en && (req_r.opcode == OP_LOG_OR)
        |-> wr_a1_o.data == (req_r.a_val | req_r.u_val))
        else $error("logical sum not bitwise");

    cov_half_sub: cover property (@(posedge clk_i) disable iff (reset_i)
        done_o && (req_r.opcode == OP_PART) && (req_r.j == J_SUB_HALF));
    cov_frac_div: cover property (@(posedge clk_i) disable iff (reset_i)
        wr_a1_o.en && (req_r.opcode == OP_DIV_FRAC));
    cov_div_ovf: cover property (@(posedge clk_i) disable iff (reset_i) error_irq_o);
    cov_back_back: cover property (@(posedge clk_i) disable iff (reset_i)
        done_o && accept_o);
endmodule

// ---- hw/dpau_pkg.sv ----
package dpau_pkg;
    // word and field geometry
    localparam int WORD_W  = 36;
    localparam int HALF_W  = 18;
    localparam int THIRD_W = 12;
    localparam int ADDR_W  = 7;
    localparam int OP_W    = 6;
    localparam int J_W     = 4;
    localparam int ASEL_W  = 4;
    localparam int CNT_W   = 10;

    // major opcodes (octal 35, 36, 72, 40, 41, 42)
    localparam logic [OP_W-1:0] OP_DIV_SINGLE = 6'h1D;
    localparam logic [OP_W-1:0] OP_DIV_FRAC   = 6'h1E;
    localparam logic [OP_W-1:0] OP_PART       = 6'h3A;
    localparam logic [OP_W-1:0] OP_LOG_OR     = 6'h20;
    localparam logic [OP_W-1:0] OP_LOG_XOR    = 6'h21;
    localparam logic [OP_W-1:0] OP_LOG_AND    = 6'h22;

    // minor codes carried in j for the partitioned group
    localparam logic [J_W-1:0] J_ADD_HALF  = 4'h4;
    localparam logic [J_W-1:0] J_SUB_HALF  = 4'h5;
    localparam logic [J_W-1:0] J_ADD_THIRD = 4'h6;
    localparam logic [J_W-1:0] J_SUB_THIRD = 4'h7;

    // film address of the first arithmetic register (octal 14)
    localparam logic [ADDR_W-1:0] A_BASE_ADDR = 7'h0C;

    // timing, figures in ns, counts rounded up to clock cycles
    localparam int CLK_NS      = 50;
    localparam int T_PART_ALT  = 4000;   // 4.0 us
    localparam int T_PART_SAME = 8000;   // 8.0 us
    localparam int T_DIV_ALT   = 31300;  // 31.3 us
    localparam int T_DIV_SAME  = 35300;  // 35.3 us
    localparam logic [CNT_W-1:0] CYC_PART_ALT  = CNT_W'((T_PART_ALT + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CYC_PART_SAME = CNT_W'((T_PART_SAME + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CYC_DIV_ALT   = CNT_W'((T_DIV_ALT + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CYC_DIV_SAME  = CNT_W'((T_DIV_SAME + CLK_NS - 1) / CLK_NS);

    // one request from instruction control
    typedef struct packed {
        logic [OP_W-1:0]   opcode;
        logic [J_W-1:0]    j;
        logic [ASEL_W-1:0] a_sel;
        logic [WORD_W-1:0] a_val;
        logic [WORD_W-1:0] a1_val;
        logic [WORD_W-1:0] u_val;
        logic              same_bank;
    } dpau_req_t;

    // one film-memory write
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } dpau_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } dpau_state_t;

    // ones'-complement add with end-around carry, 18-bit field
    function automatic logic [HALF_W-1:0] oc_add18(input logic [HALF_W-1:0] x,
                                                   input logic [HALF_W-1:0] y);
        logic [HALF_W:0] s;
        s = {1'b0, x} + {1'b0, y};
        return s[HALF_W-1:0] + HALF_W'(s[HALF_W]);
    endfunction

    // ones'-complement add with end-around carry, 12-bit field
    function automatic logic [THIRD_W-1:0] oc_add12(input logic [THIRD_W-1:0] x,
                                                    input logic [THIRD_W-1:0] y);
        logic [THIRD_W:0] s;
        s = {1'b0, x} + {1'b0, y};
        return s[THIRD_W-1:0] + THIRD_W'(s[THIRD_W]);
    endfunction
endpackage

// ---- verification/dpau_film_model.sv ----
`timescale 1ns/1ps
// film-memory stand-in: holds the arithmetic registers, feeds A and A+1
module dpau_film_model (
    input  wire logic                           clk_i,
    input  wire logic [dpau_pkg::ASEL_W-1:0]    a_sel_i,
    input  wire logic                           ld_en_i,
    input  wire logic [dpau_pkg::ADDR_W-1:0]    ld_addr_i,
    input  wire logic [dpau_pkg::WORD_W-1:0]    ld_data_i,
    input  wire dpau_pkg::dpau_wr_t             wr_a_i,
    input  wire dpau_pkg::dpau_wr_t             wr_a1_i,
    output logic [dpau_pkg::WORD_W-1:0]         a_val_o,
    output logic [dpau_pkg::WORD_W-1:0]         a1_val_o
);
    import dpau_pkg::*;

    logic [WORD_W-1:0] mem_r [0:127];   // 128-word film, never reset

    // unit writes land one edge after done, so a back-to-back read sees the old word
    always_ff @(posedge clk_i) begin
        if (ld_en_i) mem_r[ld_addr_i] <= ld_data_i;
        if (wr_a_i.en) mem_r[wr_a_i.addr] <= wr_a_i.data;
        if (wr_a1_i.en) mem_r[wr_a1_i.addr] <= wr_a1_i.data;
    end

    // no wrap: A+1 of the top register is the spare word above it
    assign a_val_o  = mem_r[A_BASE_ADDR + ADDR_W'(a_sel_i)];
    assign a1_val_o = mem_r[A_BASE_ADDR + ADDR_W'(a_sel_i) + 7'h01];
endmodule

// ---- verification/divide_partitioned_add_unit_tb.sv ----
`timescale 1ns/1ps
module divide_partitioned_add_unit_tb;
    import dpau_pkg::*;

    logic              clk_i;
    logic              reset_i;
    logic              start_i;
    dpau_req_t         req;       // bench part of the request
    dpau_req_t         req_in;    // request with film operands merged in
    logic              ready, accept, busy, done, ovf, irq;
    dpau_wr_t          wr_a, wr_a1;
    logic [WORD_W-1:0] film_a, film_a1;
    logic              ld_en;
    logic [ADDR_W-1:0] ld_addr;
    logic [WORD_W-1:0] ld_data;
    int                bad_count;
    int                tests_run;
    int                kind;

    always #25 clk_i = ~clk_i;

    // operands come from the film, as instruction control would fetch them
    always_comb begin
        req_in = req;
        req_in.a_val = film_a;
        req_in.a1_val = film_a1;
    end

    dpau_unit i_dut (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .req_i(req_in),
        .ready_o(ready), .accept_o(accept), .busy_o(busy), .done_o(done), .wr_a_o(wr_a),
        .wr_a1_o(wr_a1), .overflow_o(ovf), .error_irq_o(irq));

    dpau_film_model i_film (.clk_i(clk_i), .a_sel_i(req.a_sel), .ld_en_i(ld_en),
        .ld_addr_i(ld_addr), .ld_data_i(ld_data), .wr_a_i(wr_a), .wr_a1_i(wr_a1),
        .a_val_o(film_a), .a1_val_o(film_a1));

    task automatic report_and_stop();
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ones'-complement field add, end-around carry kept inside the field
    function automatic logic [35:0] fadd(input logic [35:0] x, input logic [35:0] y, input int w);
        logic [36:0] s;
        logic [35:0] m;
        m = (36'h1 << w) - 36'h1;
        s = {1'b0, x & m} + {1'b0, y & m};
        s = (s & {1'b0, m}) + (s >> w);
        return s[35:0] & m;
    endfunction

    // expected writes, flag and latency for one request
    function automatic void expect_op(input dpau_req_t r, output dpau_wr_t ea,
                                      output dpau_wr_t ea1, output logic eo, output int cyc);
        logic [ADDR_W-1:0] ad;
        logic [35:0]       ma, mu, res, f, m;
        logic [71:0]       d, q, rm;
        int                w;
        ad = A_BASE_ADDR + ADDR_W'(r.a_sel);
        ea = '0;
        ea1 = '0;
        eo = 1'b0;
        res = '0;
        cyc = r.same_bank ? int'(CYC_PART_SAME) : int'(CYC_PART_ALT);
        if (r.opcode == OP_PART) begin
            w = r.j[1] ? 12 : 18;   // codes 6, 7 work on thirds
            m = (36'h1 << w) - 36'h1;
            for (int k = 0; k < 36 / w; k++) begin
                f = (r.u_val >> (k * w)) & m;
                if (r.j[0]) f = ~f & m;   // subtract is add of complement
                res = res | (fadd(r.a_val >> (k * w), f, w) << (k * w));
            end
            ea = '{1'b1, ad, res};
        end else if (r.opcode == OP_DIV_SINGLE || r.opcode == OP_DIV_FRAC) begin
            cyc = r.same_bank ? int'(CYC_DIV_SAME) : int'(CYC_DIV_ALT);
            ma = r.a_val[35] ? ~r.a_val : r.a_val;
            mu = r.u_val[35] ? ~r.u_val : r.u_val;
            eo = (mu <= ma);
            d = (r.opcode == OP_DIV_FRAC) ? {r.a_val, r.a1_val} : {r.a_val, {36{r.a_val[35]}}};
            if (r.a_val[35]) d = ~d;
            d = d >> 1;
            // overflow: target addresses still shown, enable and data low
            ea1 = '{1'b0, ad + 7'h01, 36'h0};
            if (r.opcode == OP_DIV_FRAC) ea = '{1'b0, ad, 36'h0};
            if (!eo) begin
                q = d / {36'h0, mu};
                rm = d % {36'h0, mu};
                res = (r.a_val[35] ^ r.u_val[35]) ? ~q[35:0] : q[35:0];
                f = r.a_val[35] ? ~rm[35:0] : rm[35:0];
                ea1 = '{1'b1, ad + 7'h01, res};
                if (r.opcode == OP_DIV_FRAC) begin
                    ea = '{1'b1, ad, res};
                    ea1.data = f;
                end
            end
        end else begin
            res = (r.opcode == OP_LOG_OR) ? (r.a_val | r.u_val) :
                  (r.opcode == OP_LOG_XOR) ? (r.a_val ^ r.u_val) : (r.a_val & r.u_val);
            ea1 = '{1'b1, ad + 7'h01, res};
        end
    endfunction

    // one operation, launched at a falling edge, checked in its done cycle
    task automatic run_op(input logic [OP_W-1:0] o, input logic [J_W-1:0] jj,
                          input logic [ASEL_W-1:0] s, input logic [35:0] u, input logic sb);
        dpau_wr_t ea, ea1;
        logic     eo;
        int       cyc, n;
        req = '{o, jj, s, 36'h0, 36'h0, u, sb};
        start_i = 1'b1;
        #1;
        expect_op(req_in, ea, ea1, eo, cyc);
        check(48'(accept), 48'h1);
        @(posedge clk_i);
        n = 0;
        while (n < 800) begin
            @(negedge clk_i);
            n++;
            // request held on: must be ignored while running
            if (n < 3) check(48'({accept, ready, busy}), 48'h1);
            if (n == 3) start_i = 1'b0;
            if (done === 1'b1) break;
        end
        check(48'(n), 48'(cyc));
        check(48'(wr_a), 48'(ea));
        check(48'(wr_a1), 48'(ea1));
        check(48'({ovf, irq}), 48'({eo, eo}));
        if (n >= 800) report_and_stop();
    endtask

    // codes outside the set are never taken
    task automatic refuse(input logic [OP_W-1:0] o, input logic [J_W-1:0] jj);
        req = '{o, jj, 4'h0, 36'h0, 36'h0, 36'h1, 1'b0};
        start_i = 1'b1;
        #1;
        check(48'({accept, ready}), 48'h1);
        @(negedge clk_i);
        check(48'({busy, done}), 48'h0);
        start_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic load(input logic [ADDR_W-1:0] a, input logic [35:0] d);
        @(negedge clk_i);
        ld_en = 1'b1;
        ld_addr = a;
        ld_data = d;
        @(negedge clk_i);
        ld_en = 1'b0;
    endtask

    initial begin
        clk_i = 1'b0;
        reset_i = 1'b1;
        start_i = 1'b0;
        req = '0;
        ld_en = 1'b0;
        ld_addr = '0;
        ld_data = '0;
        bad_count = 0;
        tests_run = 0;
        void'($urandom(32'hdbda_6820));
        // fill the film while reset is held, then release it
        for (int i = 0; i < 17; i++) begin
            @(negedge clk_i);
            if (i == 16) begin
                check(48'({ready, accept, busy, done, ovf, irq, wr_a.en, wr_a1.en}), 48'h80);
                reset_i = 1'b0;
            end
            ld_en = 1'b1;
            ld_addr = A_BASE_ADDR + 7'(i);
            ld_data = 36'({$urandom(), $urandom()});
        end
        @(negedge clk_i);
        ld_en = 1'b0;
        // carry out of a field wraps round inside it, never into the next
        load(7'h0C, 36'h0_0003_FFFF);
        run_op(OP_PART, J_ADD_HALF, 4'h0, 36'h0_0000_0001, 1'b0);
        run_op(OP_PART, J_SUB_HALF, 4'h0, 36'h0_0002_0000, 1'b1);
        load(7'h0C, 36'h0_00FF_FFFF);
        run_op(OP_PART, J_ADD_THIRD, 4'h0, 36'h0_0000_1001, 1'b0);
        run_op(OP_PART, J_SUB_THIRD, 4'h0, 36'h8_0080_0801, 1'b1);
        // logical ops from the top register go to the spare word above
        run_op(OP_LOG_OR, 4'h0, 4'hF, 36'h5_5555_5555, 1'b0);
        run_op(OP_LOG_XOR, 4'h0, 4'hF, 36'hF_0F0F_0F0F, 1'b1);
        run_op(OP_LOG_AND, 4'h0, 4'hF, 36'h3_3333_3333, 1'b0);
        // small dividend, positive and negative divisor
        load(7'h0D, 36'h0);
        load(7'h0E, 36'h0_0000_0012);
        run_op(OP_DIV_FRAC, 4'h0, 4'h1, 36'h0_0000_0005, 1'b0);
        load(7'h0D, 36'h0);
        load(7'h0E, 36'h0_0000_0012);
        run_op(OP_DIV_FRAC, 4'h0, 4'h1, 36'hF_FFFF_FFFA, 1'b1);
        // divide overflow: zero divisor, divisor equal to upper half
        run_op(OP_DIV_SINGLE, 4'h0, 4'h2, 36'h0, 1'b1);
        load(7'h0E, 36'h0_0000_1000);
        run_op(OP_DIV_FRAC, 4'h0, 4'h2, 36'h0_0000_1000, 1'b0);
        run_op(OP_DIV_SINGLE, 4'h0, 4'h3, 36'h7_FFFF_FFFF, 1'b0);
        run_op(OP_PART, J_ADD_HALF, 4'h4, 36'hF_FFFF_FFFF, 1'b0);
        refuse(6'h00, 4'h0);
        refuse(OP_PART, 4'h3);
        // random mix, issued back to back in each done cycle
        for (int t = 0; t < 40; t++) begin
            kind = $urandom_range(0, 8);
            if (kind < 4) begin
                run_op(OP_PART, 4'(4 + kind), 4'($urandom()), 36'({$urandom(), $urandom()}),
                       1'($urandom()));
            end else begin
                run_op(kind == 4 ? OP_LOG_OR : kind == 5 ? OP_LOG_XOR : kind == 6 ? OP_LOG_AND :
                       kind == 7 ? OP_DIV_SINGLE : OP_DIV_FRAC, 4'h0, 4'($urandom()),
                       36'({$urandom(), $urandom()}), 1'($urandom()));
            end
        end
        report_and_stop();
    end
endmodule
